// ==== design/acs_pkg.sv ====
// Package of register map, field positions and timing counts
package acs_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0]  REG_STATUS_OFS   = 8'h20;
  localparam logic [7:0]  REG_THROTTLE_OFS = 8'h34;
  localparam logic [7:0]  REG_CONV_OFS     = 8'h35;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] THROTTLE_RST     = 16'h8120;
  localparam logic [15:0] CONV_RST         = 16'h2000;
  localparam logic [15:0] STATUS_RST       = 16'h0000;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int          THR_ADAPTER_BIT  = 0;
  localparam int          THR_BATTERY_BIT  = 1;
  localparam int          CONV_REPEAT_BIT  = 15;
  localparam int          CONV_START_BIT   = 14;
  localparam int          CONV_RANGE_BIT   = 13;
  localparam logic [15:0] CONV_WR_MASK     = 16'hE0FF;
  localparam int          ST_SOURCE_BIT    = 15;
  localparam int          ST_OPT_DONE_BIT  = 14;
  localparam int          ST_VOLT_REG_BIT  = 12;
  localparam int          ST_CUR_LIM_BIT   = 11;
  localparam int          ST_FAST_BIT      = 10;
  localparam int          ST_PRE_BIT       = 9;
  localparam int          ST_IN_OV_BIT     = 7;
  localparam int          ST_BAT_OC_BIT    = 6;
  localparam int          ST_IN_OC_BIT     = 5;
  localparam int          ST_SYS_OV_BIT    = 4;
  localparam int          ST_LATCHOFF_BIT  = 2;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          CLK_HZ           = 25_000_000;
  localparam int          CONV_TIME_MS     = 10;
  localparam int          REPEAT_TIME_MS   = 1000;
  localparam int          CONV_CYCLES      = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int          REPEAT_CYCLES    = CLK_HZ / 1000 * REPEAT_TIME_MS;
  localparam int          PULSE_CYCLES     = 4;
endpackage

// ==== design/acs_edge.sv ====
// Falling edge detector with one-cycle output
`timescale 1ns/1ps
`default_nettype none
module acs_edge
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic level_in,
  output var  logic fall_pulse
);
  logic prev_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_r     <= 1'b0;
      fall_pulse <= 1'b0;
    end
    else
    begin
      prev_r     <= level_in;
      fall_pulse <= prev_r & ~level_in;
    end
  end
endmodule
`default_nettype wire

// ==== design/acs_regs.sv ====
// Converter control, throttle option and charger status registers
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module acs_regs
  import acs_pkg::*;
#(
  parameter int CONV_CYC   = CONV_CYCLES,
  parameter int REPEAT_CYC = REPEAT_CYCLES
)
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output var  logic [15:0] reg_rdata,
  input  wire logic        charge_ok_pin,
  input  wire logic        battery_present,
  input  wire logic        optimizer_done,
  input  wire logic        input_volt_regulating,
  input  wire logic        input_current_limiting,
  input  wire logic        fast_charging,
  input  wire logic        precharging,
  input  wire logic        input_overvoltage_fault,
  input  wire logic        battery_overcurrent_fault,
  input  wire logic        input_overcurrent_fault,
  input  wire logic        system_overvoltage_event,
  input  wire logic        latchoff_event,
  output var  logic        processor_throttle_out,
  output var  logic        results_update,
  output var  logic        converter_range_select,
  output var  logic [7:0]  chan_enables,
  output var  logic        converter_disable
);
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_WAIT = 3'b100
  } acs_state_t;

  acs_state_t  state_r, state_nxt;
  logic [15:0] throttle_r;
  logic [15:0] conv_r;
  logic [4:0]  faults_r;
  logic [31:0] cnt_r;
  logic [2:0]  pulse_cnt_r;
  logic        batt_en_d_r;
  logic        adapter_fall;
  logic        battery_fall;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_thr    = reg_wr & hit(reg_addr, REG_THROTTLE_OFS);
  wire wr_conv   = reg_wr & hit(reg_addr, REG_CONV_OFS);
  wire wr_stat   = reg_wr & hit(reg_addr, REG_STATUS_OFS);
  wire rd_stat   = reg_rd & hit(reg_addr, REG_STATUS_OFS);
  wire batt_en   = throttle_r[THR_BATTERY_BIT];
  wire conv_done = (state_r == ST_CONV) && (cnt_r == 32'(CONV_CYC - 1));
  wire wait_done = (state_r == ST_WAIT) && (cnt_r == 32'(REPEAT_CYC - CONV_CYC - 1));
  wire start_bit = conv_r[CONV_START_BIT];
  wire repeat_md = conv_r[CONV_REPEAT_BIT];

  // ------------------------------------------------------------
  // Throttle events
  // ------------------------------------------------------------
  acs_edge u_adapter
  (
    .clk        (core_clk),
    .reset_n    (reset_n),
    .level_in   (charge_ok_pin),
    .fall_pulse (adapter_fall)
  );

  acs_edge u_battery
  (
    .clk        (core_clk),
    .reset_n    (reset_n),
    .level_in   (battery_present),
    .fall_pulse (battery_fall)
  );

  wire throttle_fire = (adapter_fall & throttle_r[THR_ADAPTER_BIT])
                     | (battery_fall & batt_en)
                     | (batt_en & ~batt_en_d_r & ~battery_present);

  wire [15:0] status_live =
      (16'(charge_ok_pin)          << ST_SOURCE_BIT)
    | (16'(optimizer_done)         << ST_OPT_DONE_BIT)
    | (16'(input_volt_regulating)  << ST_VOLT_REG_BIT)
    | (16'(input_current_limiting) << ST_CUR_LIM_BIT)
    | (16'(fast_charging)          << ST_FAST_BIT)
    | (16'(precharging)            << ST_PRE_BIT)
    | (16'(faults_r[4])            << ST_IN_OV_BIT)
    | (16'(faults_r[3])            << ST_BAT_OC_BIT)
    | (16'(faults_r[2])            << ST_IN_OC_BIT)
    | (16'(faults_r[1])            << ST_SYS_OV_BIT)
    | (16'(faults_r[0])            << ST_LATCHOFF_BIT);

  wire [4:0] fault_set = {input_overvoltage_fault, battery_overcurrent_fault,
                          input_overcurrent_fault, system_overvoltage_event,
                          latchoff_event};
  wire [4:0] fault_clr = {{3{rd_stat}}, wr_stat & ~reg_wdata[ST_SYS_OV_BIT]
                          | ~charge_ok_pin, rd_stat};
  wire [4:0] faults_nxt = (faults_r & ~fault_clr) | fault_set;

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (start_bit) state_nxt = ST_CONV;
      ST_CONV: if (conv_done) state_nxt = repeat_md ? ST_WAIT : ST_IDLE;
      ST_WAIT: if (wait_done) state_nxt = repeat_md ? ST_CONV : ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      throttle_r  <= THROTTLE_RST;
      conv_r      <= CONV_RST;
      faults_r    <= 5'h00;
      batt_en_d_r <= 1'b0;
    end
    else
    begin
      batt_en_d_r <= batt_en;
      faults_r    <= faults_nxt;
      if (wr_thr)
        throttle_r <= reg_wdata;
      if (wr_conv)
        conv_r <= reg_wdata & CONV_WR_MASK;
      else if (conv_done && !repeat_md)
        conv_r[CONV_START_BIT] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata              <= 16'h0000;
      processor_throttle_out <= 1'b1;
      pulse_cnt_r            <= 3'h0;
      results_update         <= 1'b0;
      converter_range_select <= 1'b1;
      chan_enables           <= 8'h00;
      converter_disable      <= 1'b0;
    end
    else
    begin
      if (rd_stat)
        reg_rdata <= status_live;
      else if (reg_rd)
        reg_rdata <= hit(reg_addr, REG_THROTTLE_OFS) ? throttle_r :
                     hit(reg_addr, REG_CONV_OFS) ? conv_r : 16'h0000;
      if (throttle_fire)
        pulse_cnt_r <= 3'(PULSE_CYCLES);
      else if (pulse_cnt_r != 3'h0)
        pulse_cnt_r <= pulse_cnt_r - 3'h1;
      processor_throttle_out <= ~(throttle_fire | (pulse_cnt_r > 3'h1));
      results_update         <= conv_done;
      converter_range_select <= conv_r[CONV_RANGE_BIT];
      chan_enables           <= conv_r[7:0];
      converter_disable      <= faults_nxt[1];
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_adapter_drop;
    adapter_fall && throttle_r[THR_ADAPTER_BIT];
  endsequence

  pulse_on_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_adapter_drop |=> !processor_throttle_out) else $error("no throttle pulse");
  no_pulse_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (pulse_cnt_r == 3'h0 && !throttle_fire) |=> processor_throttle_out)
    else $error("unexpected throttle");
  late_batt_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (batt_en && !batt_en_d_r && !battery_present) |=> !processor_throttle_out)
    else $error("no late battery pulse");
  start_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (conv_done && !repeat_md && !wr_conv) |=> !conv_r[CONV_START_BIT])
    else $error("start not cleared");
  conv_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_r == ST_CONV && $past(state_r) != ST_CONV) |-> cnt_r == 32'h0)
    else $error("conversion count not reset");
  fault_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (faults_r[4] && !rd_stat) |=> faults_r[4]) else $error("fault lost");
  set_wins_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (rd_stat && input_overcurrent_fault) |=> faults_r[2]) else $error("set lost");
  read_snap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (rd_stat && faults_r[3]) |=> reg_rdata[ST_BAT_OC_BIT]) else $error("snapshot wrong");
  mirror_ok_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rd_stat |=> reg_rdata[ST_SOURCE_BIT] == $past(charge_ok_pin))
    else $error("source bit mismatch");
endmodule
`default_nettype wire

// ==== tb/acs_host.sv ====
// Host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module acs_host
(
  input  wire logic        core_clk,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic [7:0]  reg_addr,
  output var  logic [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
  end
  // ------------------------------------------------------------
  // Access tasks, strobe one cycle, changed just after the edge
  // ------------------------------------------------------------
  // caller supplies register address and data values
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_adc_control_and_charger_status.sv ====
// Testbench for converter control, throttle option and status registers
`timescale 1ns/1ps
`default_nettype none
module test_adc_control_and_charger_status;
  import acs_pkg::*;
  localparam int P_CONV = 20;
  localparam int P_REP  = 100;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        charge_ok_pin   = 1'b0;
  logic        battery_present = 1'b1;
  logic [4:0]  live = 5'h00;
  logic [4:0]  flt  = 5'h00;
  logic        processor_throttle_out;
  logic        results_update;
  logic        converter_range_select;
  logic [7:0]  chan_enables;
  logic        converter_disable;
  logic [15:0] v;
  int          n;
  int          n_fail   = 0;
  int          compares = 0;
  int          cyc      = 0;
  always #20 core_clk = ~core_clk;
  acs_host u_acs_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  acs_regs #(.CONV_CYC(P_CONV), .REPEAT_CYC(P_REP)) u_acs_regs (.core_clk(core_clk),
    .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .charge_ok_pin(charge_ok_pin),
    .battery_present(battery_present), .optimizer_done(live[4]),
    .input_volt_regulating(live[3]), .input_current_limiting(live[2]),
    .fast_charging(live[1]), .precharging(live[0]), .input_overvoltage_fault(flt[4]),
    .battery_overcurrent_fault(flt[3]), .input_overcurrent_fault(flt[2]),
    .system_overvoltage_event(flt[1]), .latchoff_event(flt[0]),
    .processor_throttle_out(processor_throttle_out), .results_update(results_update),
    .converter_range_select(converter_range_select), .chan_enables(chan_enables),
    .converter_disable(converter_disable));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  task automatic wait_upd(input int lim, output int c);
    c = 0;
    do
    begin
      step();
      c++;
    end
    while (results_update !== 1'b1 && c < lim);
  endtask
  task automatic thr_pulse(output int w);
    w = 0;
    repeat (12)
    begin
      step();
      if (processor_throttle_out === 1'b0)
        w++;
    end
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    chk({7'h0, converter_range_select, chan_enables}, 16'h0100);
    chk({15'h0, processor_throttle_out}, 16'h0001);
    u_acs_host.rd(REG_CONV_OFS, v);
    chk(v, CONV_RST);
    u_acs_host.rd(REG_STATUS_OFS, v);
    chk(v, STATUS_RST);
    u_acs_host.rd(REG_THROTTLE_OFS, v);
    chk(v, THROTTLE_RST);
    u_acs_host.rd(8'h40, v);
    chk(v, 16'h0000);
    u_acs_host.wr(REG_CONV_OFS, 16'h1F5A);
    u_acs_host.rd(REG_CONV_OFS, v);
    chk(v, 16'h005A);
    chk({7'h0, converter_range_select, chan_enables}, 16'h005A);
    u_acs_host.wr(REG_CONV_OFS, 16'h20A5);
    step();
    chk({7'h0, converter_range_select, chan_enables}, 16'h01A5);
    $display("test reset and fields done");
    u_acs_host.wr(REG_CONV_OFS, 16'h6001);
    wait_upd(3 * P_REP, n);
    chk(16'(n >= P_CONV && n <= P_CONV + 5), 16'h0001);
    u_acs_host.rd(REG_CONV_OFS, v);
    chk(v, 16'h2001);
    wait_upd(3 * P_REP, n);
    chk(16'(n), 16'(3 * P_REP));
    u_acs_host.wr(REG_CONV_OFS, 16'hE000);
    wait_upd(3 * P_REP, n);
    wait_upd(3 * P_REP, n);
    chk(16'(n), 16'(P_REP));
    u_acs_host.rd(REG_CONV_OFS, v);
    chk(v, 16'hE000);
    u_acs_host.wr(REG_CONV_OFS, 16'h2000);
    $display("test conversion done");
    charge_ok_pin = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      live = (i == 5) ? 5'h1F : 5'(1 << i);
      u_acs_host.rd(REG_STATUS_OFS, v);
      chk(v, {1'b1, live[4], 1'b0, live[3:0], 9'h000});
    end
    live = 5'h00;
    flt = 5'h1F;
    step();
    flt = 5'h00;
    u_acs_host.rd(REG_STATUS_OFS, v);
    chk(v, 16'h80F4);
    chk({15'h0, converter_disable}, 16'h0001);
    u_acs_host.rd(REG_STATUS_OFS, v);
    chk(v, 16'h8010);
    u_acs_host.wr(REG_STATUS_OFS, 16'hFFFF);
    u_acs_host.rd(REG_STATUS_OFS, v);
    chk(v, 16'h8010);
    u_acs_host.wr(REG_STATUS_OFS, 16'h0000);
    u_acs_host.rd(REG_STATUS_OFS, v);
    chk(v, 16'h8000);
    chk({15'h0, converter_disable}, 16'h0000);
    flt = 5'h14;
    u_acs_host.rd(REG_STATUS_OFS, v);
    chk(v, 16'h80A0);
    flt = 5'h00;
    u_acs_host.rd(REG_STATUS_OFS, v);
    chk(v, 16'h80A0);
    $display("test status done");
    charge_ok_pin = 1'b0;
    thr_pulse(n);
    chk(16'(n), 16'h0000);
    charge_ok_pin = 1'b1;
    u_acs_host.wr(REG_THROTTLE_OFS, 16'h8121);
    step();
    charge_ok_pin = 1'b0;
    thr_pulse(n);
    chk(16'(n), 16'(PULSE_CYCLES));
    battery_present = 1'b0;
    thr_pulse(n);
    chk(16'(n), 16'h0000);
    u_acs_host.wr(REG_THROTTLE_OFS, 16'h8123);
    thr_pulse(n);
    chk(16'(n), 16'(PULSE_CYCLES));
    $display("test throttle done");
    final_report();
  end
endmodule
`default_nettype wire
